/* File: fsr_host_model.sv */
// Purpose: serial host driving the flash status block
// Assumes: mode 0, 48 ns serial clock period
// Notes: so sampled just before each falling clock
`timescale 1ns/100ps
module fsr_host_model (
    output logic      sclk,  // serial clock, idle low
    output logic      cs_n,  // chip select
    output logic      si,    // data to the device
    input  wire logic so,    // data from the device
    input  wire logic so_oe  // device drives so
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si   = 1'b0;
    end
    // one frame: opcode and data msb first, whole bytes unless a cut is wanted
    task automatic frame(input logic [7:0] op, input logic [15:0] wd, input int nb, output logic [15:0] rd);
        logic [31:0] sh;
        sh = {op, wd, 8'h00};
        rd = '0;
        cs_n = 1'b0;
        for (int i = 0; i < nb; i++) begin
            si = sh[31];
            sh = sh << 1;
            #24 sclk = 1'b1;
            #23 rd = {rd[14:0], so_oe ? so : 1'bx};
            #1 sclk = 1'b0;
        end
        #24 cs_n = 1'b1;
        si = ~si;        // released line shows no stale level
        #48;
    endtask
endmodule

/* File: fsr_pkg.sv */
// Purpose: shared constants and types of the flash status register block
// Assumes: one clock domain (ref_clk), serial link sampled as plain inputs
// Notes:   opcodes, field positions and reset values live here only
package fsr_pkg;

    // opcodes recognised by the status block
    localparam logic [7:0] FSR_OP_READ_ONE  = 8'h05;   // read first status byte
    localparam logic [7:0] FSR_OP_READ_TWO  = 8'h35;   // read second status byte
    localparam logic [7:0] FSR_OP_WRITE_SR  = 8'h01;   // write status bytes
    localparam logic [7:0] FSR_OP_WR_ENABLE = 8'h06;   // set the write enable latch

    // first status byte field positions
    localparam int FSR_B1_PROT_LO = 7;                 // status_protect_lo
    localparam int FSR_B1_SEC     = 6;                 // sector_size_select
    localparam int FSR_B1_TB      = 5;                 // top_bottom_select
    localparam int FSR_B1_BP_HI   = 4;                 // block_protect_2
    localparam int FSR_B1_BP_LO   = 2;                 // block_protect_0
    localparam int FSR_B1_WEL     = 1;                 // write_enable_latch
    localparam int FSR_B1_BUSY    = 0;                 // busy_flag

    // second status byte field positions
    localparam int FSR_B2_RSV_HI  = 7;                 // reserved_bit, reads zero
    localparam int FSR_B2_CMP     = 6;                 // complement_protect
    localparam int FSR_B2_LOCK_HI = 5;                 // security_lock_3
    localparam int FSR_B2_LOCK_LO = 3;                 // security_lock_1
    localparam int FSR_B2_RSV_LO  = 2;                 // reserved_bit, reads zero
    localparam int FSR_B2_QE      = 1;                 // quad_enable
    localparam int FSR_B2_PROT_HI = 0;                 // status_protect_hi

    // writable masks of the two bytes
    localparam logic [7:0] FSR_B1_WR_MASK = 8'hfc;     // bits 7..2
    localparam logic [7:0] FSR_B2_WR_MASK = 8'h7b;     // bits 6..3, 1, 0

    // values after power-up reset of the stored fields
    localparam logic [5:0] FSR_B1_RST     = 6'h00;     // bits 7..2 of byte one
    localparam logic [7:0] FSR_B2_RST     = 8'h00;     // stored part of byte two

    // serial frame counts
    localparam int         FSR_BYTE_BITS  = 8;         // bits per byte
    localparam logic [4:0] FSR_WR_MAX     = 5'h10;     // at most two data bytes

    // command state machine, one-hot
    typedef enum logic [4:0] {
        FSR_ST_IDLE   = 5'b00001,                      // chip not selected
        FSR_ST_OPCODE = 5'b00010,                      // shifting in opcode
        FSR_ST_READ   = 5'b00100,                      // streaming a status byte
        FSR_ST_WRITE  = 5'b01000,                      // collecting write data
        FSR_ST_IGNORE = 5'b10000                       // frame ignored until deselect
    } fsr_state_e;

    // status write permission from the two protect bits and the pin level
    function automatic logic fsr_write_ok(input logic prot_hi, input logic prot_lo,
                                          input logic wp_level, input logic write_enable_latch);
        logic ok;
        ok = 1'b0;
        if (!prot_hi && !prot_lo) begin
            ok = write_enable_latch;                                  // software protected
        end else if (!prot_hi && prot_lo) begin
            ok = write_enable_latch & wp_level;                       // hardware protected by pin
        end
        return ok;                                     // lock-down and one-time states refuse
    endfunction

endpackage

/* File: fsr_shift.sv */
// Purpose: serialises the selected status byte, msb first, repeating
// Assumes: shift_en marks a falling serial clock during a read
// Notes:   a fresh snapshot is taken at the start of every byte
`timescale 1ns/100ps
module fsr_shift
    import fsr_pkg::*;
(
    input  wire logic ref_clk,                         // block clock
    input  wire logic rst,                             // async reset, high
    fsr_tx_if.shf     tx                               // link to command logic
);
    logic [7:0] snap_r;                                // remaining bits of snapshot
    logic [2:0] bit_r;                                 // position within byte
    logic       so_r;                                  // registered output bit

    assign tx.so = so_r;

    // load or shift on every falling serial clock of a read
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            snap_r <= 8'h00;
            bit_r  <= 3'h0;
            so_r   <= 1'b0;
        end else if (!tx.run) begin
            bit_r  <= 3'h0;                            // next read starts at bit 7
        end else if (tx.shift_en) begin
            bit_r  <= bit_r + 3'h1;                    // wraps after bit 0
            if (bit_r == 3'h0) begin
                so_r   <= tx.data[7];                  // fresh contents each pass
                snap_r <= {tx.data[6:0], 1'b0};
            end else begin
                so_r   <= snap_r[7];                   // msb first
                snap_r <= {snap_r[6:0], 1'b0};
            end
        end
    end
endmodule

/* File: fsr_sync.sv */
// Purpose: two flip-flop synchroniser for inputs from outside ref_clk
// Assumes: inputs are slow levels relative to ref_clk
// Notes:   the first stage is read by the second stage only
`timescale 1ns/100ps
module fsr_sync
    import fsr_pkg::*;
#(
    parameter int         W       = 1,                 // number of bits
    parameter logic [W-1:0] RST_VAL = '0               // idle level of the pins
) (
    input  wire logic         ref_clk,                 // block clock
    input  wire logic         rst,                     // async reset, high
    input  wire logic [W-1:0] d_in,                    // raw pin levels
    output logic      [W-1:0] q_out                    // synchronised levels
);
    logic [W-1:0] meta_r;                              // first stage

    // two stage sampling
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_r <= RST_VAL;
            q_out  <= RST_VAL;
        end else begin
            meta_r <= d_in;
            q_out  <= meta_r;
        end
    end
endmodule

/* File: fsr_top.sv */
// Purpose: status register bank of a serial flash with its read and write commands
// Assumes: serial link in mode 0 or 3, sclk far slower than ref_clk
// Notes:   array engine reports busy and write-enable clears on the same clock
//
// Operation
// - status read accepted even while busy
// - opcode 05h streams first status byte
// - opcode 35h streams second status byte
// - msb first, wraps to bit 7 repeatedly
// - every repetition shows current contents
// - deselect ends read, output floats
// - partial byte on deselect is harmless
// - byte one holds protect, select, block bits
// - bit 1 is read-only write enable latch
// - bit 0 is read-only busy flag
// - write of byte one alters bits 7..2
// - byte two reserved bits zero, complement bit
// - three page lock bits refuse program/erase
// - quad enable turns pins to data
// - write of byte two alters 6..3,1,0
// - protect 00: write allowed with latch set
// - protect 01: pin low blocks writes
// - protect 10: locked until power cycle
// - protect 11: writes refused for good; here power-up reset clears it like 10
// - latch clear: modifying commands ignored
// - write ends on byte boundary, else abort
`timescale 1ns/100ps
module fsr_top
    import fsr_pkg::*;
(
    input  wire logic       ref_clk,               // 200 MHz block clock
    input  wire logic       rst,                   // async reset, high, power-up
    input  wire logic       spi_sclk,              // serial clock pin
    input  wire logic       spi_cs_n,              // chip select pin, low active
    input  wire logic       spi_si,                // serial data in pin
    input  wire logic       wp_n,                  // write protect pin, low active
    input  wire logic       busy_in,               // array engine busy, same clock
    input  wire logic       wel_clear,             // engine op ended or aborted, pulse
    output logic            spi_so,                // serial data out
    output logic            spi_so_oe,             // serial out driven when high
    output logic            wel_out,               // write enable latch level
    output logic [2:0]      block_protect,         // block_protect_2..0
    output logic            sector_size_select,    // small or large protect blocks
    output logic            top_bottom_select,     // protect from top or bottom
    output logic            complement_protect,    // inverts protected area
    output logic [2:0]      security_lock,         // security_lock_3..1
    output logic            quad_enable            // hold and wp act as data pins
);

    // ---- synchronised pins
    logic       sclk_s;                            // sclk after two flops
    logic       cs_n_s;                            // chip select after two flops
    logic       si_s;                              // data in after two flops
    logic       wp_n_s;                            // protect pin after two flops
    logic       sclk_d_r;                          // previous sclk level
    logic       cs_n_d_r;                          // previous chip select level

    // all pins cross into ref_clk before anything looks at them
    fsr_sync #(
        .W       (4),
        .RST_VAL (4'h6)
    ) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .d_in    ({spi_sclk, spi_cs_n, wp_n, spi_si}),
        .q_out   ({sclk_s, cs_n_s, wp_n_s, si_s})
    );

    // ---- edge detection
    wire        selected   = ~cs_n_s;              // chip is selected
    wire        sclk_rise  = selected & sclk_s & ~sclk_d_r;   // data sample point
    wire        sclk_fall  = selected & ~sclk_s & sclk_d_r;   // data launch point
    wire        cs_start   = ~cs_n_s & cs_n_d_r;  // frame begins
    wire        cs_end     = cs_n_s & ~cs_n_d_r;  // frame ends

    // remember last levels for edge finding
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sclk_d_r <= 1'b0;
            cs_n_d_r <= 1'b1;
        end else begin
            sclk_d_r <= sclk_s;
            cs_n_d_r <= cs_n_s;
        end
    end

    // ---- stored status fields
    logic [5:0] b1_r;                              // byte one bits 7..2
    logic [7:0] b2_r;                              // byte two stored bits
    logic       wel_r;                             // write enable latch
    logic       busy_r;                            // registered busy flag

    // ---- command state
    fsr_state_e state_r;                           // present state
    fsr_state_e state_nxt;                         // next state
    logic [7:0] op_r;                              // opcode shift register
    logic [2:0] opcnt_r;                           // opcode bits taken
    logic       sel_two_r;                         // read streams byte two
    logic [15:0] wbuf_r;                           // write data shifted in
    logic [4:0] wcnt_r;                            // write bits taken, saturating
    logic       wover_r;                           // more than two bytes sent

    // ---- assembled status bytes
    wire [7:0]  status_one = {b1_r, wel_r, busy_r};   // bit1 latch, bit0 busy
    wire [7:0]  status_two = b2_r & FSR_B2_WR_MASK;   // reserved bits forced zero

    // ---- opcode decode once the eighth bit lands
    wire [7:0]  op_full    = {op_r[6:0], si_s};   // opcode including current bit
    wire        op_done    = sclk_rise & (opcnt_r == 3'h7);
    wire        op_rd_one  = op_full == FSR_OP_READ_ONE;
    wire        op_rd_two  = op_full == FSR_OP_READ_TWO;
    wire        op_wr_sr   = op_full == FSR_OP_WRITE_SR;
    wire        op_wr_en   = op_full == FSR_OP_WR_ENABLE;

    // ---- status write permission and completion
    wire        wp_level   = wp_n_s | b2_r[FSR_B2_QE];  // pin is data when quad enabled
    wire        wr_allowed = fsr_write_ok(b2_r[FSR_B2_PROT_HI], b1_r[FSR_B1_PROT_LO - 2],
                                          wp_level, wel_r);
    wire        in_write   = state_r == FSR_ST_WRITE;
    wire        wr_whole   = (wcnt_r == 5'h08) | (wcnt_r == FSR_WR_MAX);   // byte boundary
    wire        wr_commit  = in_write & cs_end & wr_whole & ~wover_r & wr_allowed;
    wire        wr_two     = wcnt_r == FSR_WR_MAX;    // optional second byte sent
    wire        wr_finish  = in_write & cs_end;       // latch drops on success or abort

    // ---- byte one and two images after a committed write
    wire [7:0]  b1_first   = wr_two ? wbuf_r[15:8] : wbuf_r[7:0];
    wire [7:0]  b2_second  = wbuf_r[7:0];
    wire [5:0]  b1_new     = b1_first[7:2];                          // only bits 7..2
    wire [7:0]  b2_new     = (b2_second & FSR_B2_WR_MASK) | (b2_r & ~FSR_B2_WR_MASK);

    // ---- next state of the command machine
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            FSR_ST_IDLE: begin
                if (cs_start) begin
                    state_nxt = FSR_ST_OPCODE;     // new frame
                end
            end
            FSR_ST_OPCODE: begin
                if (cs_n_s) begin
                    state_nxt = FSR_ST_IDLE;       // partial opcode dropped
                end else if (op_done) begin
                    if (op_rd_one || op_rd_two) begin
                        state_nxt = FSR_ST_READ;   // read taken any time, busy too
                    end else if (op_wr_sr && wel_r) begin
                        state_nxt = FSR_ST_WRITE;  // needs the latch set
                    end else begin
                        state_nxt = FSR_ST_IGNORE; // other or refused opcode
                    end
                end
            end
            FSR_ST_READ: begin
                if (cs_n_s) begin
                    state_nxt = FSR_ST_IDLE;       // deselect ends the read
                end
            end
            FSR_ST_WRITE: begin
                if (cs_n_s) begin
                    state_nxt = FSR_ST_IDLE;       // commit or abort decided on cs_end
                end
            end
            FSR_ST_IGNORE: begin
                if (cs_n_s) begin
                    state_nxt = FSR_ST_IDLE;
                end
            end
            default: begin
                state_nxt = FSR_ST_IDLE;           // recover from an illegal code
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= FSR_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // opcode collection, restarted by every frame start
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            op_r    <= 8'h00;
            opcnt_r <= 3'h0;
        end else if (cs_start) begin
            op_r    <= 8'h00;
            opcnt_r <= 3'h0;
        end else if (sclk_rise && state_r == FSR_ST_OPCODE) begin
            op_r    <= op_full;
            opcnt_r <= opcnt_r + 3'h1;
        end
    end

    // byte selection for the read, held for the whole frame
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sel_two_r <= 1'b0;
        end else if (op_done && state_r == FSR_ST_OPCODE) begin
            sel_two_r <= op_rd_two;                // 35h picks byte two
        end
    end

    // write data collection, counts bits up to a saturation mark
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wbuf_r  <= 16'h0000;
            wcnt_r  <= 5'h00;
            wover_r <= 1'b0;
        end else if (cs_start) begin
            wbuf_r  <= 16'h0000;
            wcnt_r  <= 5'h00;
            wover_r <= 1'b0;
        end else if (sclk_rise && in_write) begin
            wbuf_r <= {wbuf_r[14:0], si_s};
            if (wcnt_r == FSR_WR_MAX) begin
                wover_r <= 1'b1;                   // third byte means abort
            end else begin
                wcnt_r <= wcnt_r + 5'h01;
            end
        end
    end

    // stored fields: only a permitted, whole-byte write changes them
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            b1_r <= FSR_B1_RST;                    // power cycle frees lock-down
            b2_r <= FSR_B2_RST;
        end else if (wr_commit) begin
            b1_r <= b1_new;
            if (wr_two) begin
                b2_r <= b2_new;
            end
        end
    end

    // write enable latch: set by its opcode, cleared by write end or engine
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wel_r <= 1'b0;                         // not enabled after power-up
        end else if (op_done && state_r == FSR_ST_OPCODE && op_wr_en) begin
            wel_r <= 1'b1;                         // set wins over a clear
        end else if (wr_finish || wel_clear) begin
            wel_r <= 1'b0;                         // ends or aborts drop it
        end
    end

    // busy follows the array engine so reads during an operation see it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= busy_in;
        end
    end

    // ---- output serialiser
    fsr_tx_if tx ();                               // command to shifter link

    assign tx.run      = state_r == FSR_ST_READ;
    assign tx.shift_en = sclk_fall;                                  // launch on falling sclk
    assign tx.data     = sel_two_r ? status_two : status_one;        // live contents

    fsr_shift u_shift (
        .ref_clk (ref_clk),
        .rst     (rst),
        .tx      (tx)
    );

    // output enable rises with the first launched bit of a read
    logic       oe_r;                              // serial out driven
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            oe_r <= 1'b0;
        end else if (state_r != FSR_ST_READ || cs_n_s) begin
            oe_r <= 1'b0;                          // float once deselected
        end else if (sclk_fall) begin
            oe_r <= 1'b1;
        end
    end

    assign spi_so    = tx.so;
    assign spi_so_oe = oe_r & ~cs_n_s;            // released as soon as cs rises

    // ---- field outputs to the rest of the device
    assign wel_out            = wel_r;                               // gates modifying commands
    assign block_protect      = b1_r[FSR_B1_BP_HI - 2:FSR_B1_BP_LO - 2];
    assign sector_size_select = b1_r[FSR_B1_SEC - 2];
    assign top_bottom_select  = b1_r[FSR_B1_TB - 2];
    assign complement_protect = b2_r[FSR_B2_CMP];
    assign security_lock      = b2_r[FSR_B2_LOCK_HI:FSR_B2_LOCK_LO];    // page refusal
    assign quad_enable        = b2_r[FSR_B2_QE];                        // pin role switch

endmodule

/* File: fsr_top_properties.sv */
// Purpose: port assertions of the status register block
// Assumes: one clock domain, serial pins seen raw
// Notes: bound from the bench top
`timescale 1ns/100ps
module fsr_top_properties
    import fsr_pkg::*;
(
    input wire logic       ref_clk,       // block clock
    input wire logic       rst,           // async reset
    input wire logic       spi_sclk,      // serial clock
    input wire logic       spi_cs_n,      // chip select
    input wire logic       wel_clear,     // engine clear pulse
    input wire logic       spi_so,        // serial out
    input wire logic       spi_so_oe,     // serial out enable
    input wire logic       wel_out,       // latch level
    input wire logic [2:0] block_protect, // byte one field
    input wire logic [2:0] security_lock, // byte two field
    input wire logic       quad_enable    // byte two field
);
    logic [6:0] sck_d;                                  // serial clock history
    // short history of the sampled serial clock
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) sck_d <= '0;
        else sck_d <= {sck_d[5:0], spi_sclk};
    end
    wire fell_near = |(sck_d[6:1] & ~sck_d[5:0]);       // a fall seen lately
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence cs_idle; spi_cs_n [*4]; endsequence         // deselected a while
    sequence cs_busy; !spi_cs_n [*4]; endsequence        // selected a while
    oe_release_a: assert property (cs_idle |-> !spi_so_oe)
        else $error("serial out driven while deselected");
    oe_select_a: assert property ($rose(spi_so_oe) |-> !$past(spi_cs_n, 2))
        else $error("serial out enabled without selection");
    so_timing_a: assert property (spi_so_oe && $past(spi_so_oe) && $changed(spi_so) |-> fell_near)
        else $error("serial out moved away from a clock fall");
    wel_set_a: assert property ($rose(wel_out) |-> !$past(spi_cs_n, 2))
        else $error("latch set outside a frame");
    wel_clear_a: assert property (cs_idle ##0 wel_clear |=> !wel_out)
        else $error("latch kept after clear pulse");
    prot_stable_a: assert property (cs_busy |-> $stable(block_protect))
        else $error("byte one field moved inside a frame");
    lock_stable_a: assert property (cs_busy |-> $stable(security_lock) && $stable(quad_enable))
        else $error("byte two field moved inside a frame");
    field_moment_a: assert property ($changed(block_protect) |-> $past(spi_cs_n, 3))
        else $error("field update not at frame end");
endmodule

/* File: fsr_top_tb.sv */
// Purpose: self-checking bench of the status register block
// Assumes: host model frames every access
// Notes: each read returns two copies of the byte
`timescale 1ns/100ps
module fsr_top_tb;
    import fsr_pkg::*;
    logic        ref_clk, rst, spi_sclk, spi_cs_n, spi_si, wp_n, busy_in, wel_clear;
    logic        spi_so, spi_so_oe, wel_out, sector_size_select, top_bottom_select;
    logic        complement_protect, quad_enable;
    logic [2:0]  block_protect, security_lock;
    logic [15:0] rd;
    int          miscompares = 0;
    int          cmp_count = 0;
    fsr_top DUT (.*);
    fsr_host_model host (.sclk(spi_sclk), .cs_n(spi_cs_n), .si(spi_si), .so(spi_so), .so_oe(spi_so_oe));
    always #2.5 ref_clk = ~ref_clk;
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // read a byte, compare both copies and the released output
    task automatic rd_sr(input logic [7:0] op, input logic [7:0] exp);
        host.frame(op, 16'h0, 24, rd);
        cmp8(rd[15:8], exp);
        cmp8(rd[7:0], exp);
        cmp8({7'h0, spi_so_oe}, 8'h00);
    endtask
    // set the latch, then write one or two bytes
    task automatic wr_sr(input logic [15:0] wd, input int nb);
        host.frame(FSR_OP_WR_ENABLE, 16'h0, 8, rd);
        host.frame(FSR_OP_WRITE_SR, wd, nb, rd);
    endtask
    task automatic reset_dut();
        @(negedge ref_clk) rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask
    task automatic done(input string s);
        $display("test %s done at %0t", s, $time);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog well beyond the expected run
    initial begin
        #200000 miscompares++;
        report_and_stop();
    end
    // main sequence
    initial begin
        ref_clk = 1'b0;
        rst = 1'b1;
        wp_n = 1'b1;
        busy_in = 1'b0;
        wel_clear = 1'b0;
        reset_dut();
        rd_sr(FSR_OP_READ_ONE, 8'h00);
        rd_sr(FSR_OP_READ_TWO, 8'h00);
        done("reset");
        host.frame(FSR_OP_WR_ENABLE, 16'h0, 8, rd);
        rd_sr(FSR_OP_READ_ONE, 8'h02);
        @(negedge ref_clk) wel_clear = 1'b1;
        @(negedge ref_clk) wel_clear = 1'b0;
        rd_sr(FSR_OP_READ_ONE, 8'h00);
        host.frame(FSR_OP_WRITE_SR, 16'hfc00, 16, rd);
        rd_sr(FSR_OP_READ_ONE, 8'h00);
        done("latch");
        wr_sr(16'h7ffe, 24);
        rd_sr(FSR_OP_READ_ONE, 8'h7c);
        rd_sr(FSR_OP_READ_TWO, 8'h7a);
        cmp8({block_protect, sector_size_select, top_bottom_select,
              complement_protect, quad_enable, wel_out}, 8'hfe);
        cmp8({5'h0, security_lock}, 8'h07);
        done("write");
        @(negedge ref_clk) busy_in = 1'b1;
        fork
            host.frame(FSR_OP_READ_ONE, 16'h0, 24, rd);
            begin
                #600 @(negedge ref_clk) busy_in = 1'b0;
            end
        join
        cmp8(rd[15:8], 8'h7d);
        cmp8(rd[7:0], 8'h7c);
        done("busy");
        wr_sr(16'h0000, 12);
        rd_sr(FSR_OP_READ_ONE, 8'h7c);
        host.frame(FSR_OP_READ_ONE, 16'h0, 11, rd);
        rd_sr(FSR_OP_READ_TWO, 8'h7a);
        done("abort");
        wr_sr(16'h8000, 24);
        rd_sr(FSR_OP_READ_TWO, 8'h00);
        @(negedge ref_clk) wp_n = 1'b0;
        wr_sr(16'h0000, 16);
        rd_sr(FSR_OP_READ_ONE, 8'h80);
        @(negedge ref_clk) wp_n = 1'b1;
        wr_sr(16'h0001, 24);
        rd_sr(FSR_OP_READ_ONE, 8'h00);
        wr_sr(16'h1c00, 16);
        rd_sr(FSR_OP_READ_TWO, 8'h01);
        reset_dut();
        rd_sr(FSR_OP_READ_TWO, 8'h00);
        @(negedge ref_clk) wp_n = 1'b0;
        wr_sr(16'h1c00, 16);
        rd_sr(FSR_OP_READ_ONE, 8'h1c);
        wr_sr(16'h8001, 24);
        @(negedge ref_clk) wp_n = 1'b1;
        wr_sr(16'h0000, 24);
        rd_sr(FSR_OP_READ_TWO, 8'h01);
        rd_sr(FSR_OP_READ_ONE, 8'h80);
        done("protect");
        report_and_stop();
    end
endmodule
bind fsr_top fsr_top_properties chk (.*);

/* File: fsr_tx_if.sv */
// Purpose: carrier between command logic and the output serialiser
// Assumes: all signals on ref_clk
// Notes:   ctl drives the strobes and byte, shf returns the serial bit
`timescale 1ns/100ps
interface fsr_tx_if;
    logic       run;                                   // a status read is streaming
    logic       shift_en;                              // falling serial clock seen
    logic [7:0] data;                                  // live contents of selected byte
    logic       so;                                    // bit presented on serial out
    modport ctl (output run, output shift_en, output data, input so);
    modport shf (input run, input shift_en, input data, output so);
endinterface
